//--- hw/xaf_core.sv
// Execution block: XOR accumulator with file register
// Contract
// RULE1: XOR accumulator with addressed file register, 0..127
// RULE2: Opcode 000110, bit7 dest, bits6-0 address
// RULE3: Dest 0 writes accumulator, file unchanged
// RULE4: Dest 1 writes file, accumulator unchanged
// RULE5: Zero flag from result, one cycle
`timescale 1ns/1ps
`include "xaf_regs.svh"
module xaf_core #(
    parameter int DATA_W = `XAF_DATA_W,
    parameter int DEPTH  = `XAF_FILE_DEPTH
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // Instruction issue
    input  wire logic              instr_valid,
    input  wire logic [13:0]       instr,
    // Architectural state
    output logic [DATA_W-1:0]      accum,
    output logic                   zero_flag,
    output logic                   done
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] acc;
        logic              z;
        logic              done;
    } xaf_state_t;

    xaf_state_t        st_q;
    xaf_state_t        st_d;
    logic [DATA_W-1:0] file_q [DEPTH];
    logic [DATA_W-1:0] result;
    logic              exec;
    logic              wr_file;
    xaf_dec_if         dif ();

    xaf_decode u_dec (
        .instr (instr),
        .dec_o (dif.drv)
    );

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    localparam int ADDR_W = `XAF_ADDR_W;

    // True when the result goes back to the file register
    function automatic logic is_file_dest(input xaf_pkg::xaf_dest_t d);
        return d == xaf_pkg::XAF_DEST_REG;
    endfunction

    // ----------------------------------------
    // Datapath
    // ----------------------------------------
    assign exec    = instr_valid && dif.dec.hit;
    assign result  = st_q.acc ^ file_q[dif.dec.addr]; // RULE1
    assign wr_file = exec && is_file_dest(dif.dec.dest); // RULE4

    always_comb begin
        st_d      = st_q;
        st_d.done = exec; // RULE5
        if (exec) begin
            if (!is_file_dest(dif.dec.dest)) begin
                st_d.acc = result; // RULE3
            end
            st_d.z = (result == '0); // RULE5
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------
    // File registers
    // ----------------------------------------
    // Each entry resets to its own address, so data is varied from reset
    for (genvar g = 0; g < DEPTH; g++) begin : g_file
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                file_q[g] <= DATA_W'(g ^ `XAF_FILE_RST);
            end else if (wr_file && dif.dec.addr == ADDR_W'(g)) begin
                file_q[g] <= result; // RULE4
            end
        end
    end

    assign accum     = st_q.acc;
    assign zero_flag = st_q.z;
    assign done      = st_q.done;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Operands as seen from the ports, independent of the decoder
    logic [DATA_W-1:0] sel_file;
    logic [DATA_W-1:0] exp_res;
    logic              op_seen;

    assign sel_file = file_q[instr[6:0]];
    assign exp_res  = accum ^ sel_file;
    assign op_seen  = instr_valid && instr[13:8] == 6'h06;

    property p_acc_dest;
        @(posedge clk) disable iff (sys_rst)
        op_seen && !instr[7] |=> accum == $past(exp_res);
    endproperty
    a_acc_dest: assert property (p_acc_dest) // RULE3
        else $error("accumulator not loaded with result");

    property p_file_keep;
        @(posedge clk) disable iff (sys_rst)
        op_seen && !instr[7]
        |=> file_q[$past(instr[6:0])] == $past(sel_file);
    endproperty
    a_file_keep: assert property (p_file_keep) // RULE3
        else $error("file register changed on accumulator destination");

    property p_acc_hold;
        @(posedge clk) disable iff (sys_rst)
        op_seen && instr[7] |=> $stable(accum);
    endproperty
    a_acc_hold: assert property (p_acc_hold) // RULE4
        else $error("accumulator changed on file destination");

    property p_file_write;
        @(posedge clk) disable iff (sys_rst)
        op_seen && instr[7]
        |=> file_q[$past(instr[6:0])] == $past(exp_res);
    endproperty
    a_file_write: assert property (p_file_write) // RULE4
        else $error("file register not written");

    property p_xor_value;
        @(posedge clk) disable iff (sys_rst)
        op_seen |=> zero_flag == ($past(accum) == $past(sel_file));
    endproperty
    a_xor_value: assert property (p_xor_value) // RULE1
        else $error("zero flag disagrees with operand equality");

    property p_acc_from_file;
        @(posedge clk) disable iff (sys_rst)
        op_seen && !instr[7] && accum == '0
        |=> accum == $past(sel_file);
    endproperty
    a_acc_from_file: assert property (p_acc_from_file) // RULE1
        else $error("xor with zero accumulator wrong");

    property p_zero_flag;
        @(posedge clk) disable iff (sys_rst)
        op_seen |=> zero_flag == ($past(exp_res) == '0);
    endproperty
    a_zero_flag: assert property (p_zero_flag) // RULE5
        else $error("zero flag wrong");

    property p_zero_file;
        @(posedge clk) disable iff (sys_rst)
        op_seen && instr[7]
        |=> zero_flag == (file_q[$past(instr[6:0])] == '0);
    endproperty
    a_zero_file: assert property (p_zero_file) // RULE5
        else $error("zero flag does not match stored result");

    property p_zero_hold;
        @(posedge clk) disable iff (sys_rst)
        !op_seen |=> $stable(zero_flag) && $stable(accum);
    endproperty
    a_zero_hold: assert property (p_zero_hold) // RULE5
        else $error("state changed without instruction");

    property p_one_cycle;
        @(posedge clk) disable iff (sys_rst)
        op_seen |=> done;
    endproperty
    a_one_cycle: assert property (p_one_cycle) // RULE5
        else $error("operation not done in one cycle");

    property p_decode_hit;
        @(posedge clk) disable iff (sys_rst)
        instr_valid && instr[13:8] != 6'h06 |=> !done;
    endproperty
    a_decode_hit: assert property (p_decode_hit) // RULE2
        else $error("foreign opcode executed");

    property p_idle_done;
        @(posedge clk) disable iff (sys_rst)
        !instr_valid |=> !done;
    endproperty
    a_idle_done: assert property (p_idle_done) // RULE2
        else $error("invalid slot executed");

    property p_hit_exact;
        @(posedge clk) disable iff (sys_rst)
        instr_valid |-> dif.dec.hit == (instr[13:8] == 6'h06);
    endproperty
    a_hit_exact: assert property (p_hit_exact) // RULE2
        else $error("decoder hit wrong");

    for (genvar g = 0; g < DEPTH; g++) begin : g_file_chk
        a_file_other: assert property ( // RULE4
            @(posedge clk) disable iff (sys_rst)
            !(op_seen && instr[7] && instr[6:0] == ADDR_W'(g))
            |=> $stable(file_q[g]))
            else $error("unaddressed file register changed");
    end

    // ----------------------------------------
    // Cover points
    // ----------------------------------------
    c_to_acc:  cover property (@(posedge clk) op_seen && !instr[7]);
    c_to_file: cover property (@(posedge clk) op_seen && instr[7]);
    c_zero:    cover property (@(posedge clk) op_seen ##1 zero_flag);
    c_b2b:     cover property (@(posedge clk) op_seen ##1 op_seen);
    c_refused: cover property (@(posedge clk) instr_valid && !op_seen);
endmodule

//--- hw/xaf_dec_if.sv
// Decoded instruction fields passed from decoder to datapath
`timescale 1ns/1ps
interface xaf_dec_if;
    xaf_pkg::xaf_dec_t dec;
    modport drv (output dec);
    modport use_ (input dec);
endinterface

//--- hw/xaf_decode.sv
// Instruction decoder for the XOR of accumulator with file register
`timescale 1ns/1ps
`include "xaf_regs.svh"
module xaf_decode (
    // Instruction word
    input  wire logic [13:0] instr,
    // Decoded fields
    xaf_dec_if.drv           dec_o
);
    always_comb begin
        dec_o.dec.hit  = (instr[`XAF_OP_HI_MSB:`XAF_OP_HI_LSB]
                          == `XAF_OP_XOR_FILE); // RULE2
        dec_o.dec.dest = instr[`XAF_DEST_BIT] ? xaf_pkg::XAF_DEST_REG
                                              : xaf_pkg::XAF_DEST_ACC; // RULE2
        dec_o.dec.addr = instr[`XAF_ADDR_MSB:0]; // RULE2
    end
endmodule

//--- hw/xaf_pkg.sv
// Types shared by the XOR execution block
package xaf_pkg;
    typedef enum logic [0:0] {
        XAF_DEST_ACC,
        XAF_DEST_REG
    } xaf_dest_t;

    typedef struct packed {
        logic       hit;
        xaf_dest_t  dest;
        logic [6:0] addr;
    } xaf_dec_t;
endpackage

//--- hw/xaf_regs.svh
// Constants for the accumulator-with-file XOR execution block
`ifndef XAF_REGS_SVH
`define XAF_REGS_SVH

`define XAF_OPCODE_W        14
`define XAF_DATA_W          8
`define XAF_ADDR_W          7
`define XAF_FILE_DEPTH      128
`define XAF_OP_HI_MSB       13
`define XAF_OP_HI_LSB       8
`define XAF_OP_XOR_FILE     6'h06
`define XAF_DEST_BIT        7
`define XAF_ADDR_MSB        6
`define XAF_DEST_ACCUM      1'b0
`define XAF_DEST_FILE       1'b1
`define XAF_ACCUM_RST       8'h00
`define XAF_FILE_RST        8'h00

`endif

//--- tb/tb_top.sv
// Self-checking bench for the XOR execution block
`timescale 1ns/1ps
module tb_top;
    logic        clk, sys_rst, instr_valid, zero_flag, done, v;
    logic [13:0] instr, w;
    logic [7:0]  accum, acc_m, r;
    logic [7:0]  file_m [128];
    logic [15:0] e;
    logic [15:0] exp_q [$];
    logic [31:0] rs;
    int          num_errors, n_compared;
    xaf_core dut (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
        .instr(instr), .accum(accum), .zero_flag(zero_flag), .done(done));
    xaf_fetch_model pm (.clk(clk), .instr_valid(instr_valid),
        .instr(instr));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic send(input logic sv, input logic [13:0] sw);
        if (sv && sw[13:8] == 6'h06) begin
            r = acc_m ^ file_m[sw[6:0]];
            if (sw[7]) file_m[sw[6:0]] = r;
            else acc_m = r;
            exp_q.push_back({acc_m, r});
        end
        pm.issue(sv, sw);
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] ex);
        n_compared++;
        if (seen !== ex) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, seen, ex);
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #(300 * 50);
        num_errors++;
        wrap_up();
    end
    // Result monitor
    always @(posedge clk) begin
        #1;
        if (!sys_rst && done === 1'b1) begin
            if (exp_q.size() == 0)
                chk(8'hff, 8'h00);
            else begin
                e = exp_q.pop_front();
                chk(accum, e[15:8]);
                chk({7'h00, zero_flag}, {7'h00, e[7:0] == 8'h00});
            end
        end
    end
    initial begin
        sys_rst = 1'b1;
        num_errors = 0;
        n_compared = 0;
        rs = 32'hd9d3fb88;
        acc_m = 8'h00;
        foreach (file_m[i]) file_m[i] = 8'(i);
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        chk(accum, 8'h00);
        chk({6'h00, zero_flag, done}, 8'h00);
        $display("test reset done");
        send(1'b1, 14'h0600);
        send(1'b1, 14'h0605);
        send(1'b1, 14'h0685);
        send(1'b1, 14'h0605);
        send(1'b1, 14'h0603);
        send(1'b1, 14'h3a05);
        send(1'b0, 14'h0605);
        $display("test directed done");
        for (int i = 0; i < 80; i++) begin
            rs = xs(rs);
            v = rs[31] | rs[30];
            w = {rs[13] ? 6'h06 : rs[29:24], rs[7:0]};
            send(v, w);
        end
        pm.issue(1'b0, 14'h0000);
        repeat (3) @(posedge clk);
        chk(8'(exp_q.size()), 8'h00);
        foreach (file_m[i]) chk(dut.file_q[i], file_m[i]);
        $display("test random stream done");
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        chk(accum, 8'h00);
        chk({6'h00, zero_flag, done}, 8'h00);
        foreach (file_m[i]) chk(dut.file_q[i], 8'(i));
        $display("test reset in run done");
        wrap_up();
    end
endmodule

//--- tb/xaf_fetch_model.sv
// Fetch stage model issuing instruction words
`timescale 1ns/1ps
module xaf_fetch_model (
    // Clock
    input  wire logic        clk,
    // Issue
    output logic             instr_valid,
    output logic [13:0]      instr
);
    initial begin
        instr_valid = 1'b0;
        instr       = 14'h0000;
    end
    task automatic issue(input logic v, input logic [13:0] w);
        @(posedge clk);
        instr_valid <= v;
        instr       <= w;
    endtask
endmodule
